// ### rtl/phalu_core.sv
// Purpose: combinational packed integer datapath
// Assumes: op, operands stable for one cycle before capture
// Notes:   64-bit form uses low halves and returns zero in the upper half
`timescale 1ns/100ps
module phalu_core
  import phalu_pkg::*;
(
  phalu_if.core c
);
  `include "phalu_regs.svh"

  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v > $signed({2'h0, `PHALU_SAT_MAX})) begin
      sat16 = `PHALU_SAT_MAX;
    end else if (v < $signed({2'h3, `PHALU_SAT_MIN})) begin
      sat16 = `PHALU_SAT_MIN;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // 64-bit form packs both halves into the low 128 bits of the pool
  logic [255:0] pool;
  logic [127:0] mask;
  logic [127:0] r_addw, r_addws, r_subw, r_subws, r_addd, r_subd;
  logic [127:0] r_absb, r_absw, r_absd, r_madd;
  assign pool = c.w64 ? {128'h0, c.src[63:0], c.dst[63:0]} : {c.src, c.dst};
  assign mask = c.w64 ? {64'h0, {64{1'b1}}} : {128{1'b1}};

  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_word
      logic [15:0] lo, hi;
      logic signed [17:0] sum, dif;
      logic signed [17:0] pa, pb;
      assign lo = pool[32*k +: 16];
      assign hi = pool[32*k+16 +: 16];
      assign sum = $signed({{2{lo[15]}}, lo}) + $signed({{2{hi[15]}}, hi});
      assign dif = $signed({{2{lo[15]}}, lo}) - $signed({{2{hi[15]}}, hi});
      assign r_addw[16*k +: 16] = sum[15:0];
      assign r_addws[16*k +: 16] = sat16(sum);
      assign r_subw[16*k +: 16] = dif[15:0];
      assign r_subws[16*k +: 16] = sat16(dif);
      // products fit 16 bits signed; the pair sum needs 17
      assign pa = $signed({10'h0, c.dst[16*k +: 8]}) *
                  $signed({{10{c.src[16*k+7]}}, c.src[16*k +: 8]});
      assign pb = $signed({10'h0, c.dst[16*k+8 +: 8]}) *
                  $signed({{10{c.src[16*k+15]}}, c.src[16*k+8 +: 8]});
      assign r_madd[16*k +: 16] = sat16(pa + pb) & mask[16*k +: 16];
      assign r_absw[16*k +: 16] = (c.src[16*k+15] ? -c.src[16*k +: 16] :
                                  c.src[16*k +: 16]) & mask[16*k +: 16];
    end
    for (k = 0; k < 4; k++) begin : g_dword
      logic [31:0] lo, hi;
      assign lo = pool[64*k +: 32];
      assign hi = pool[64*k+32 +: 32];
      assign r_addd[32*k +: 32] = lo + hi;
      assign r_subd[32*k +: 32] = lo - hi;
      assign r_absd[32*k +: 32] = (c.src[32*k+31] ? -c.src[32*k +: 32] :
                                  c.src[32*k +: 32]) & mask[32*k +: 32];
    end
    for (k = 0; k < 16; k++) begin : g_byte
      assign r_absb[8*k +: 8] = (c.src[8*k+7] ? -c.src[8*k +: 8] :
                                c.src[8*k +: 8]) & mask[8*k +: 8];
    end
  endgenerate

  always_comb begin
    c.bad = 1'b0;
    unique case (c.op)
      OP_HADD_WORD_WRAP: c.res = r_addw;
      OP_HADD_WORD_SAT:  c.res = r_addws;
      OP_HADD_DWORD:     c.res = r_addd;
      OP_HSUB_WORD_WRAP: c.res = r_subw;
      OP_HSUB_WORD_SAT:  c.res = r_subws;
      OP_HSUB_DWORD:     c.res = r_subd;
      OP_ABS_BYTE:       c.res = r_absb;
      OP_ABS_WORD:       c.res = r_absw;
      OP_ABS_DWORD:      c.res = r_absd;
      OP_BYTE_MUL_PAIR:  c.res = r_madd;
      default: begin
        c.res = `PHALU_RST_128;
        c.bad = 1'b1;
      end
    endcase
  end
endmodule // phalu_core

// ### rtl/phalu_if.sv
// Purpose: operand and result carrier between register file and datapath
// Assumes: datapath is purely combinational
// Notes:   none
`timescale 1ns/100ps
interface phalu_if;
  import phalu_pkg::*;
  logic [3:0]  op;
  phalu_vec_t  dst;
  phalu_vec_t  src;
  logic        w64;
  phalu_vec_t  res;
  logic        bad;
  modport core (input op, dst, src, w64, output res, bad);
  modport user (output op, dst, src, w64, input res, bad);
endinterface // phalu_if

// ### rtl/phalu_pkg.sv
// Purpose: types shared by the packed horizontal alu files
// Assumes: nothing
// Notes:   op codes 10..15 are illegal
package phalu_pkg;
  typedef enum logic [3:0] {
    OP_HADD_WORD_WRAP   = 4'h0,
    OP_HADD_WORD_SAT    = 4'h1,
    OP_HADD_DWORD       = 4'h2,
    OP_HSUB_WORD_WRAP   = 4'h3,
    OP_HSUB_WORD_SAT    = 4'h4,
    OP_HSUB_DWORD       = 4'h5,
    OP_ABS_BYTE         = 4'h6,
    OP_ABS_WORD         = 4'h7,
    OP_ABS_DWORD        = 4'h8,
    OP_BYTE_MUL_PAIR    = 4'h9
  } phalu_op_e;
  typedef logic [127:0] phalu_vec_t;
endpackage

// ### rtl/phalu_regs.svh
// Purpose: register map, field positions and fixed values of the packed horizontal alu
// Assumes: byte addresses on a 32-bit avalon slave, one word per register
// Notes:   feature values are fixed at build time
// Behaviour
// - horizontal ops in 64 and 128 forms, both operands
// - word add wraps, packs 16-bit pair sums
// - word add saturating clamps to signed 16
// - dword add packs 32-bit pair sums
// - word subtract: lower minus upper, wrapping
// - word subtract saturating, lower minus upper
// - dword subtract: lower minus upper dword
// - absolute value bytes, words, dwords, unsigned result
// - unsigned dst byte times signed src byte
// - adjacent products summed, saturated to signed 16
// - 64 or 128-bit operands, byte/word/dword elements
// - leaf 01H result_reg_c bit 0 reports extensions
// - truncating store shares that same feature bit
// - leaf 01H result_reg_c bit 3 reports watch/wait
// - watch/wait always at ring 0, else gated
// - leaf 05H line sizes in a/b bits 15:0
`ifndef PHALU_REGS_SVH
`define PHALU_REGS_SVH

`define PHALU_ADDR_DST0   8'h00
`define PHALU_ADDR_SRC0   8'h10
`define PHALU_ADDR_CTRL   8'h20
`define PHALU_ADDR_STATUS 8'h24
`define PHALU_ADDR_PRIV   8'h28
`define PHALU_ADDR_LEAF   8'h2C
`define PHALU_ADDR_FEATA  8'h30
`define PHALU_ADDR_FEATB  8'h34
`define PHALU_ADDR_FEATC  8'h38
`define PHALU_ADDR_RES0   8'h40
`define PHALU_ADDR_OPGRP  4
`define PHALU_OP_LSB      0
`define PHALU_OP_MSB      3
`define PHALU_W64_BIT     4
`define PHALU_GO_BIT      8
`define PHALU_ST_DONE     0
`define PHALU_ST_BAD      1
`define PHALU_ST_WATCH    2
`define PHALU_ST_BUSY     3
`define PHALU_PRIV_RING_MSB 1
`define PHALU_PRIV_USER   2
`define PHALU_RING_KERNEL 2'h0
`define PHALU_LEAF_BASIC  32'h0000_0001
`define PHALU_LEAF_WATCH  32'h0000_0005
`define PHALU_FEAT_EXT_BIT   0
`define PHALU_FEAT_WATCH_BIT 3
`define PHALU_HAS_EXT     1'h1
`define PHALU_HAS_WATCH   1'h1
`define PHALU_LINE_MIN    16'h0040
`define PHALU_LINE_MAX    16'h0040
`define PHALU_SAT_MAX     16'h7FFF
`define PHALU_SAT_MIN     16'h8000
`define PHALU_RST_WORD    32'h0000_0000
`define PHALU_RST_128     128'h0

`endif

// ### rtl/phalu_top.sv
// Purpose: avalon-mm register front end around the packed horizontal alu
// Assumes: one 50 MHz clock, master holds requests until waitrequest is low
// Notes:   every access answers in the cycle after it is presented
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module phalu_top
  import phalu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  `include "phalu_regs.svh"

  phalu_if bus ();

  logic [127:0] dst;
  logic [127:0] src;
  logic [127:0] res;
  logic [3:0]   op_q;
  logic         w64_q;
  logic         pend;
  logic         done;
  logic         bad;
  logic [1:0]   ring;
  logic         user_en;
  logic [31:0]  leaf;
  logic         wr_acc;
  logic [31:0]  bmask;
  logic [31:0]  next_readdata;
  logic [31:0]  feat_a;
  logic [31:0]  feat_b;
  logic [31:0]  feat_c;
  logic         watch_ok;
  logic [1:0]   widx;
  logic         go_wr;
  logic         st_clr;

  // one wait state per access keeps the read mux off the bus path
  assign wr_acc = avs_write & ~avs_waitrequest;
  assign widx   = avs_address[3:2];
  assign bmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign go_wr  = wr_acc && avs_address == `PHALU_ADDR_CTRL && avs_writedata[`PHALU_GO_BIT];
  assign st_clr = wr_acc && avs_address == `PHALU_ADDR_STATUS &&
                  avs_writedata[`PHALU_ST_DONE];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // operand words, byte lanes honoured
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dst <= `PHALU_RST_128;
      src <= `PHALU_RST_128;
    end else if (wr_acc && avs_address[7:4] == `PHALU_ADDR_DST0 >> `PHALU_ADDR_OPGRP) begin
      dst[32*widx +: 32] <= (dst[32*widx +: 32] & ~bmask) | (avs_writedata & bmask);
    end else if (wr_acc && avs_address[7:4] == `PHALU_ADDR_SRC0 >> `PHALU_ADDR_OPGRP) begin
      src[32*widx +: 32] <= (src[32*widx +: 32] & ~bmask) | (avs_writedata & bmask);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_q  <= OP_HADD_WORD_WRAP;
      w64_q <= 1'b0;
    end else if (wr_acc && avs_address == `PHALU_ADDR_CTRL) begin
      op_q  <= avs_writedata[`PHALU_OP_MSB:`PHALU_OP_LSB];
      w64_q <= avs_writedata[`PHALU_W64_BIT];
    end
  end

  assign bus.op  = op_q;
  assign bus.dst = dst;
  assign bus.src = src;
  assign bus.w64 = w64_q;

  phalu_core u_core (
    .c (bus.core)
  );

  // result is sampled the cycle after go, so the op and width written with go settle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend <= 1'b0;
    end else begin
      pend <= go_wr;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res <= `PHALU_RST_128;
      bad <= 1'b0;
    end else if (pend) begin
      res <= bus.res;
      bad <= bus.bad;
    end
  end

  // set beats clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
    end else if (pend) begin
      done <= 1'b1;
    end else if (st_clr) begin
      done <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ring    <= `PHALU_RING_KERNEL;
      user_en <= 1'b0;
      leaf    <= `PHALU_RST_WORD;
    end else if (wr_acc && avs_address == `PHALU_ADDR_PRIV) begin
      ring    <= avs_writedata[`PHALU_PRIV_RING_MSB:0];
      user_en <= avs_writedata[`PHALU_PRIV_USER];
    end else if (wr_acc && avs_address == `PHALU_ADDR_LEAF) begin
      leaf    <= avs_writedata;
    end
  end

  // truncating store has no bit of its own; software tests the extension bit
  always_comb begin
    feat_a = `PHALU_RST_WORD;
    feat_b = `PHALU_RST_WORD;
    feat_c = `PHALU_RST_WORD;
    if (leaf == `PHALU_LEAF_BASIC) begin
      feat_c[`PHALU_FEAT_EXT_BIT]   = `PHALU_HAS_EXT;
      feat_c[`PHALU_FEAT_WATCH_BIT] = `PHALU_HAS_WATCH;
    end else if (leaf == `PHALU_LEAF_WATCH) begin
      feat_a[15:0] = `PHALU_LINE_MIN;
      feat_b[15:0] = `PHALU_LINE_MAX;
    end
  end

  // outer rings need the user enable; ring 0 needs only the feature
  assign watch_ok = `PHALU_HAS_WATCH && (ring == `PHALU_RING_KERNEL || user_en);

  always_comb begin
    next_readdata = `PHALU_RST_WORD;
    if (avs_address[7:4] == `PHALU_ADDR_DST0 >> `PHALU_ADDR_OPGRP) begin
      next_readdata = dst[32*widx +: 32];
    end else if (avs_address[7:4] == `PHALU_ADDR_SRC0 >> `PHALU_ADDR_OPGRP) begin
      next_readdata = src[32*widx +: 32];
    end else if (avs_address[7:4] == `PHALU_ADDR_RES0 >> `PHALU_ADDR_OPGRP) begin
      next_readdata = res[32*widx +: 32];
    end else if (avs_address == `PHALU_ADDR_CTRL) begin
      next_readdata[`PHALU_OP_MSB:`PHALU_OP_LSB] = op_q;
      next_readdata[`PHALU_W64_BIT] = w64_q;
    end else if (avs_address == `PHALU_ADDR_STATUS) begin
      next_readdata[`PHALU_ST_DONE]  = done;
      next_readdata[`PHALU_ST_BAD]   = bad;
      next_readdata[`PHALU_ST_WATCH] = watch_ok;
      next_readdata[`PHALU_ST_BUSY]  = pend;
    end else if (avs_address == `PHALU_ADDR_PRIV) begin
      next_readdata[`PHALU_PRIV_RING_MSB:0] = ring;
      next_readdata[`PHALU_PRIV_USER] = user_en;
    end else if (avs_address == `PHALU_ADDR_LEAF) begin
      next_readdata = leaf;
    end else if (avs_address == `PHALU_ADDR_FEATA) begin
      next_readdata = feat_a;
    end else if (avs_address == `PHALU_ADDR_FEATB) begin
      next_readdata = feat_b;
    end else if (avs_address == `PHALU_ADDR_FEATC) begin
      next_readdata = feat_c;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= `PHALU_RST_WORD;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  wait_answer_a: assert property (@(posedge clk) disable iff (!arst_n)
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered in one cycle");

  wait_single_a: assert property (@(posedge clk) disable iff (!arst_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  done_after_go_a: assert property (@(posedge clk) disable iff (!arst_n)
    go_wr |=> pend ##1 (done && !pend))
    else $error("done not set two cycles after go");

  hadd_word_a: assert property (@(posedge clk) disable iff (!arst_n)
    pend && op_q == OP_HADD_WORD_WRAP && !w64_q |=>
    res[15:0] == $past(dst[15:0] + dst[31:16]) &&
    res[79:64] == $past(src[15:0] + src[31:16]))
    else $error("wrapping word add pair wrong");

  hsub_dword_a: assert property (@(posedge clk) disable iff (!arst_n)
    pend && op_q == OP_HSUB_DWORD && w64_q |=>
    res[31:0] == $past(dst[31:0] - dst[63:32]) &&
    res[63:32] == $past(src[31:0] - src[63:32]) && res[127:64] == 64'h0)
    else $error("dword subtract or 64-bit placement wrong");

  hsub_sat_a: assert property (@(posedge clk) disable iff (!arst_n)
    pend && op_q == OP_HSUB_WORD_SAT && dst[15:0] == 16'h8000 &&
    dst[31:16] == 16'h0001 |=> res[15:0] == 16'h8000)
    else $error("saturating subtract did not clamp low");

  hadd_sat_a: assert property (@(posedge clk) disable iff (!arst_n)
    pend && op_q == OP_HADD_WORD_SAT && dst[15:0] == 16'h7FFF &&
    dst[31:16] == 16'h0002 |=> res[15:0] == 16'h7FFF)
    else $error("saturating add did not clamp high");

  abs_byte_a: assert property (@(posedge clk) disable iff (!arst_n)
    pend && op_q == OP_ABS_BYTE && !w64_q |=>
    res[7:0] == ($past(src[7]) ? 8'h0 - $past(src[7:0]) : $past(src[7:0])))
    else $error("byte absolute value wrong");

  madd_pair_a: assert property (@(posedge clk) disable iff (!arst_n)
    pend && op_q == OP_BYTE_MUL_PAIR && !w64_q && dst[111:96] == 16'hFFFF &&
    src[111:96] == 16'h7F7F |=> res[111:96] == 16'h7FFF)
    else $error("byte multiply pair not saturated");

  feat_leaf_a: assert property (@(posedge clk) disable iff (!arst_n)
    leaf == `PHALU_LEAF_BASIC |-> feat_c[`PHALU_FEAT_EXT_BIT] && feat_c[`PHALU_FEAT_WATCH_BIT]
    && feat_a == `PHALU_RST_WORD)
    else $error("basic leaf feature bits wrong");

  watch_ring_a: assert property (@(posedge clk) disable iff (!arst_n)
    ring == `PHALU_RING_KERNEL |-> watch_ok)
    else $error("watch/wait refused at ring 0");
endmodule // phalu_top

// ### tb/phalu_host.sv
// Purpose: avalon-mm master standing in for the processor decode side
// Assumes: slave drops waitrequest for one cycle per access
// Notes:   released write data shows the inverse, never a stale copy
`timescale 1ns/100ps
module phalu_host (
  input  wire logic        clk,
  output logic [7:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address    <= 8'h00;
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    avs_writedata  <= 32'h0000_0000;
    avs_byteenable <= 4'hF;
  end

  // no bound of its own: a dead slave is caught by the bench watchdog
  task automatic await_ack();
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    await_ack();
    avs_write     <= 1'b0;
    avs_writedata <= ~d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read    <= 1'b1;
    await_ack();
    d = avs_readdata;
    avs_read    <= 1'b0;
    @(posedge clk);
  endtask
endmodule // phalu_host

// ### tb/phalu_top_tb.sv
// Purpose: self-checking bench for the packed horizontal alu
// Assumes: 50 MHz clock, one-cycle register answers
// Notes:   expected results come from a reference model kept here
`timescale 1ns/100ps
`include "phalu_regs.svh"
module phalu_top_tb
  import phalu_pkg::*;
;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          miscompares = 0;
  int          checked = 0;

  always #10 clk = ~clk;

  phalu_top dut (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  phalu_host u_host (
    .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic int sat16(input int v);
    return (v > 32767) ? 32767 : (v < -32768) ? -32768 : v;
  endfunction

  // 64-bit form: low halves in, upper 64 of the result zero
  function automatic phalu_vec_t ref_op(input logic [3:0] op, input logic w64,
                                        input phalu_vec_t d, input phalu_vec_t s);
    phalu_vec_t r;
    phalu_vec_t v;
    int         n, m, j, a, b, x;
    r = '0;
    n = w64 ? 64 : 128;
    case (op)
      4'h0, 4'h1, 4'h3, 4'h4: for (int k = 0; k < n / 16; k++) begin
        m = n / 32;
        v = (k < m) ? d : s;
        j = k % m;
        a = $signed(v[32*j +: 16]);
        b = $signed(v[32*j+16 +: 16]);
        x = (op < 4'h3) ? a + b : a - b;
        if (op == 4'h1 || op == 4'h4)
          x = sat16(x);
        r[16*k +: 16] = x[15:0];
      end
      4'h2, 4'h5: for (int k = 0; k < n / 32; k++) begin
        m = n / 64;
        v = (k < m) ? d : s;
        j = k % m;
        a = v[64*j +: 32];
        b = v[64*j+32 +: 32];
        x = (op == 4'h2) ? a + b : a - b;
        r[32*k +: 32] = x;
      end
      4'h6: for (int k = 0; k < n / 8; k++) begin
        a = $signed(s[8*k +: 8]);
        x = (a < 0) ? -a : a;
        r[8*k +: 8] = x[7:0];
      end
      4'h7: for (int k = 0; k < n / 16; k++) begin
        a = $signed(s[16*k +: 16]);
        x = (a < 0) ? -a : a;
        r[16*k +: 16] = x[15:0];
      end
      4'h8: for (int k = 0; k < n / 32; k++) begin
        a = s[32*k +: 32];
        x = (a < 0) ? -a : a;
        r[32*k +: 32] = x;
      end
      4'h9: for (int k = 0; k < n / 16; k++) begin
        a = d[16*k +: 8];
        b = $signed(s[16*k +: 8]);
        x = a * b;
        a = d[16*k+8 +: 8];
        b = $signed(s[16*k+8 +: 8]);
        x = sat16(x + a * b);
        r[16*k +: 16] = x[15:0];
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  task automatic run_op(input logic [3:0] op, input logic w64,
                        input phalu_vec_t d, input phalu_vec_t s);
    phalu_vec_t  exp;
    logic [31:0] st;
    int          n;
    exp = ref_op(op, w64, d, s);
    for (int i = 0; i < 4; i++) begin
      u_host.wr(`PHALU_ADDR_DST0 + 8'(4 * i), d[32*i +: 32]);
      u_host.wr(`PHALU_ADDR_SRC0 + 8'(4 * i), s[32*i +: 32]);
    end
    u_host.wr(`PHALU_ADDR_CTRL, {23'h0, 1'b1, 3'h0, w64, op});
    n = 0;
    do begin
      u_host.rd(`PHALU_ADDR_STATUS, st);
      n++;
    end while (st[`PHALU_ST_DONE] !== 1'b1 && n < 8);
    chk({30'h0, st[1:0]}, {30'h0, op > 4'h9, 1'b1});
    u_host.rd(`PHALU_ADDR_CTRL, st);
    chk(st, {27'h0, w64, op});
    for (int i = 0; i < 4; i++) begin
      u_host.rd(`PHALU_ADDR_RES0 + 8'(4 * i), st);
      chk(st, exp[32*i +: 32]);
    end
    u_host.wr(`PHALU_ADDR_STATUS, 32'h1);
  endtask

  task automatic t_idle();
    logic [31:0] v;
    u_host.rd(`PHALU_ADDR_STATUS, v);
    chk(v, 32'h4);
    u_host.rd(`PHALU_ADDR_RES0, v);
    chk(v, 32'h0);
    u_host.wr(8'hF0, 32'hA5A5_A5A5);
    u_host.rd(8'hF0, v);
    chk(v, 32'h0);
    $display("test idle done");
  endtask

  task automatic t_feature();
    logic [31:0] v;
    u_host.wr(`PHALU_ADDR_LEAF, `PHALU_LEAF_BASIC);
    u_host.rd(`PHALU_ADDR_FEATC, v);
    chk({30'h0, v[3], v[0]}, 32'h3);
    u_host.wr(`PHALU_ADDR_LEAF, `PHALU_LEAF_WATCH);
    u_host.rd(`PHALU_ADDR_FEATA, v);
    chk({16'h0, v[15:0]}, {16'h0, `PHALU_LINE_MIN});
    u_host.rd(`PHALU_ADDR_FEATB, v);
    chk({16'h0, v[15:0]}, {16'h0, `PHALU_LINE_MAX});
    u_host.wr(`PHALU_ADDR_LEAF, 32'h2);
    u_host.rd(`PHALU_ADDR_FEATC, v);
    chk(v, 32'h0);
    $display("test feature done");
  endtask

  task automatic t_priv();
    logic [31:0] v;
    logic [2:0]  p[5] = '{3'h0, 3'h3, 3'h1, 3'h7, 3'h4};
    foreach (p[i]) begin
      u_host.wr(`PHALU_ADDR_PRIV, {29'h0, p[i]});
      u_host.rd(`PHALU_ADDR_STATUS, v);
      chk({31'h0, v[2]}, {31'h0, p[i][1:0] == 2'h0 || p[i][2]});
    end
    u_host.wr(`PHALU_ADDR_PRIV, 32'h0);
    $display("test priv done");
  endtask

  // saturation edges, most negative elements and full-range bytes
  task automatic t_ops();
    phalu_vec_t  dv[2] = '{128'h7FFF_0001_8000_FFFF_7FFF_7FFF_0001_8000,
                           128'hFFFF_FFFF_0102_0304_8000_0000_0002_7FFF};
    phalu_vec_t  sv[2] = '{128'h8000_7FFF_0001_8000_80FF_7F01_FF80_0180,
                           128'h8080_7F7F_0180_FF01_8000_0000_8000_0001};
    logic [31:0] v;
    for (int t = 0; t < 2; t++)
      for (int op = 0; op < 10; op++)
        for (int w = 0; w < 2; w++)
          run_op(4'(op), 1'(w), dv[t], sv[t]);
    run_op(4'hA, 1'b0, dv[0], sv[0]);
    run_op(4'hF, 1'b1, dv[1], sv[1]);
    u_host.rd(`PHALU_ADDR_STATUS, v);
    chk({31'h0, v[0]}, 32'h0);
    $display("test ops done");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    chk({31'h0, avs_waitrequest}, 32'h1);
    chk(avs_readdata, 32'h0);
    arst_n <= 1'b1;
    @(posedge clk);
    t_idle();
    t_feature();
    t_priv();
    t_ops();
    tally_and_finish();
  end

  // the run needs about 2100 cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule // phalu_top_tb
